// ===== rtl/acs_consts.vh
// constants shared by the converter control/status block
`ifndef ACS_CONSTS_VH
`define ACS_CONSTS_VH

// register byte offsets on the register bus
`define ACS_OFF_CSR      8'h00
`define ACS_OFF_TRG      8'h04
`define ACS_OFF_RES0     8'h08
`define ACS_OFF_RES3     8'h14

// control/status field positions
`define ACS_B_FLAG       7
`define ACS_B_IE         6
`define ACS_B_START      5
`define ACS_B_SCAN       4
`define ACS_B_SPEED      3
`define ACS_B_CH_HI      2
`define ACS_B_CH_LO      0

// trigger control field positions and reserved read pattern
`define ACS_B_EXTERNAL_TRIGGER_ENABLE       7
`define ACS_TRG_RSVD     8'h7E

// reset values
`define ACS_CSR_RST      8'h00
`define ACS_RES_RST      16'h0000

// result placement: 10-bit value left-justified
`define ACS_RES_LSB      6
`define ACS_RES_PAD      6'h00

// conversion times in states; one state is one clock
`define ACS_T_FIRST_SLOW 134
`define ACS_T_FIRST_FAST 70
`define ACS_T_NEXT_SLOW  128
`define ACS_T_NEXT_FAST  66
`define ACS_STATE_NS     40
`define ACS_CLK_NS       40
`define ACS_CYC(s)       (((s) * `ACS_STATE_NS) / `ACS_CLK_NS)

// bus response codes
`define ACS_RESP_OKAY    2'h0
`define ACS_RESP_SLVERR  2'h2

`endif

// ===== rtl/acs_trig_sync.v
// synchroniser and falling-edge detector for the external trigger pin
`timescale 1ns/100ps
module acs_trig_sync (
    // clock and reset
    input  wire aclk,
    input  wire aresetn,
    // raw pin and detected edge
    input  wire pin_in,
    output reg  fall_q
);
    reg meta_q;  // first stage, read only by the second stage
    reg sync_q;  // second stage, safe to use
    reg prev_q;  // delayed copy for edge detection

    // two flops before use, then compare with the last value;
    // pin idles high after reset so no false edge at release
    always @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            prev_q <= 1'b1;
            fall_q <= 1'b0;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
            fall_q <= prev_q & ~sync_q;
        end
    end
endmodule // acs_trig_sync

// ===== rtl/acs_result_mem.v
// four-word result store with registered read port
`timescale 1ns/100ps
`include "acs_consts.vh"
module acs_result_mem #(
    parameter AW = 2,
    parameter DW = 16
) (
    // clock and reset
    input  wire          aclk,
    input  wire          aresetn,
    // write port from the sequencer
    input  wire          we,
    input  wire [AW-1:0] waddr,
    input  wire [DW-1:0] wdata,
    // read port toward the bus
    input  wire [AW-1:0] raddr,
    output reg  [DW-1:0] rdata_q
);
    reg [DW-1:0] mem_q [0:(1<<AW)-1]; // one word per channel
    integer      i;

    // results clear on reset so a read before any conversion gives zero
    always @(posedge aclk) begin
        if (!aresetn) begin
            for (i = 0; i < (1<<AW); i = i + 1) begin
                mem_q[i] <= `ACS_RES_RST;
            end
            rdata_q <= `ACS_RES_RST;
        end else begin
            if (we) begin
                mem_q[waddr] <= wdata;
            end
            rdata_q <= mem_q[raddr];
        end
    end
endmodule // acs_result_mem

// ===== rtl/acs_top.v
// converter control/status block with register bus slave
//
// Functional notes
// - single mode: flag set when conversion ends
// - scan mode: flag set after whole group
// - flag clears by read-as-one then write zero
// - interrupt when flag and enable both set
// - writing one to start bit starts conversion
// - single mode: start bit self-clears at end
// - scan repeats until software, reset, standby
// - mode bit: 0 single, 1 scan
// - speed bit: 134 or 70 states maximum
// - single: low two bits pick channel
// - scan: low two bits pick group size
// - all control/status bits zero on reset
// - results left-justified, one register per channel
// - scan restarts at group's first channel
// - scan repeats take 128 or 66 states
// - enabled trigger falling edge sets start
//
// Chosen here: the address map and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "acs_consts.vh"
module acs_top #(
    parameter AW = 8,   // register bus address width
    parameter RW = 10,  // converter result width
    parameter CW = 8    // conversion timer width
) (
    // clock and reset
    input  wire          aclk,
    input  wire          aresetn,
    // register bus write address channel
    input  wire [AW-1:0] awaddr,
    input  wire          awvalid,
    output reg           awready,
    // register bus write data channel
    input  wire [31:0]   wdata,
    input  wire [3:0]    wstrb,
    input  wire          wvalid,
    output reg           wready,
    // register bus write response channel
    output reg  [1:0]    bresp,
    output reg           bvalid,
    input  wire          bready,
    // register bus read address channel
    input  wire [AW-1:0] araddr,
    input  wire          arvalid,
    output reg           arready,
    // register bus read data channel
    output reg  [31:0]   rdata,
    output reg  [1:0]    rresp,
    output reg           rvalid,
    input  wire          rready,
    // analog conversion core
    output reg           conv_start,
    output reg           conv_abort,
    output reg  [1:0]    conv_channel,
    output reg           conv_speed,
    input  wire [RW-1:0] conv_result,
    // system and pins
    input  wire          standby_req,
    input  wire          external_trigger_input,
    output reg           conversion_end_interrupt
);
    // control/status fields
    reg          flag_q, flag_d;     // conversion end flag
    reg          ie_q, ie_d;         // end interrupt enable
    reg          start_q, start_d;   // conversion start bit
    reg          scan_q, scan_d;     // mode select
    reg          speed_q, speed_d;   // conversion speed select
    reg  [2:0]   chsel_q, chsel_d;   // channel select, top bit unused
    reg          external_trigger_enable_q, external_trigger_enable_d;     // external trigger enable
    reg          arm_q, arm_d;       // flag was read as one
    // sequencer state
    reg          run_q, run_d;       // a conversion is in flight
    reg  [CW-1:0] cnt_q, cnt_d;      // states left in conversion
    reg  [1:0]   chan_q, chan_d;     // channel being converted
    reg          cstart_d;           // start pulse to the core
    reg          abort_d;            // abort pulse to the core
    reg          mem_we;             // store a finished result
    // write path state
    reg          aw_got_q;           // address held
    reg          w_got_q;            // data held
    reg  [AW-1:0] waddr_q;           // held write address
    reg  [7:0]   wbyte_q;            // held low data byte
    reg          wlane_q;            // low byte lane enabled
    // read path state
    reg          rd_pend_q;          // read accepted, data next edge
    reg  [AW-1:0] raddr_q;           // held read address
    // misc nets
    wire         trig_fall;          // synchronised trigger edge
    wire [15:0]  mem_rdata;          // registered result word
    wire [AW-1:0] ridx_full;         // result index from read address
    wire [7:0]   csr_view;           // control/status as read
    wire         wr_fire;            // both write halves present
    wire         csr_wr;             // effective control write
    wire         trg_wr;             // effective trigger write
    wire         csr_rd_done;        // control read answered now

    localparam [31:0] LEN_FST_F = `ACS_CYC(`ACS_T_FIRST_FAST);
    localparam [31:0] LEN_FST_S = `ACS_CYC(`ACS_T_FIRST_SLOW);
    localparam [31:0] LEN_NXT_F = `ACS_CYC(`ACS_T_NEXT_FAST);
    localparam [31:0] LEN_NXT_S = `ACS_CYC(`ACS_T_NEXT_SLOW);
    // conversion length for the current speed; first one of a run
    // takes the longest time in the range, repeats the fixed time;
    // lengths are sliced to the timer width on purpose
    function [CW-1:0] conv_len;
        input first;
        input fast;
        begin
            if (first) begin
                conv_len = fast ? LEN_FST_F[CW-1:0]
                                : LEN_FST_S[CW-1:0];
            end else begin
                conv_len = fast ? LEN_NXT_F[CW-1:0]
                                : LEN_NXT_S[CW-1:0];
            end
        end
    endfunction

    // true for any address that holds a register
    function is_mapped;
        input [AW-1:0] a;
        begin
            is_mapped = (a[1:0] == 2'h0) &&
                        (a <= `ACS_OFF_RES3);
        end
    endfunction

    // trigger pin goes through two flops before use
    acs_trig_sync u_trig (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin_in  (external_trigger_input),
        .fall_q  (trig_fall)
    );

    // result index: offsets 08..14 map to words 0..3
    assign ridx_full = araddr - `ACS_OFF_RES0;

    acs_result_mem #(
        .AW (2),
        .DW (16)
    ) u_mem (
        .aclk    (aclk),
        .aresetn (aresetn),
        .we      (mem_we),
        .waddr   (chan_q),
        .wdata   ({conv_result, `ACS_RES_PAD}),
        .raddr   (ridx_full[3:2]),
        .rdata_q (mem_rdata)
    );

    // register image as software sees it
    assign csr_view = {flag_q, ie_q, start_q, scan_q, speed_q, chsel_q};

    assign wr_fire     = aw_got_q & w_got_q & ~bvalid;
    assign csr_wr      = wr_fire & wlane_q & (waddr_q == `ACS_OFF_CSR);
    assign trg_wr      = wr_fire & wlane_q & (waddr_q == `ACS_OFF_TRG);
    assign csr_rd_done = rd_pend_q & (raddr_q == `ACS_OFF_CSR);

    // next state of the register fields and the sequencer
    always @* begin
        flag_d   = flag_q;
        ie_d     = ie_q;
        start_d  = start_q;
        scan_d   = scan_q;
        speed_d  = speed_q;
        chsel_d  = chsel_q;
        external_trigger_enable_d   = external_trigger_enable_q;
        arm_d    = arm_q;
        run_d    = run_q;
        cnt_d    = cnt_q;
        chan_d   = chan_q;
        cstart_d = 1'b0;
        abort_d  = 1'b0;
        mem_we   = 1'b0;
        // a read that returns the flag as one arms the clear
        if (csr_rd_done) begin
            arm_d = flag_q;
        end
        // software write; writing one to the flag has no effect
        if (csr_wr) begin
            ie_d    = wbyte_q[`ACS_B_IE];
            scan_d  = wbyte_q[`ACS_B_SCAN];
            speed_d = wbyte_q[`ACS_B_SPEED];
            chsel_d = wbyte_q[`ACS_B_CH_HI:`ACS_B_CH_LO];
            start_d = wbyte_q[`ACS_B_START];
            if (!wbyte_q[`ACS_B_FLAG] && arm_q) begin
                flag_d = 1'b0;
            end
            // a write without the prior read leaves the flag set
            arm_d = 1'b0;
        end
        if (trg_wr) begin
            external_trigger_enable_d = wbyte_q[`ACS_B_EXTERNAL_TRIGGER_ENABLE];
        end
        // enabled trigger edge acts like a software start
        if (trig_fall && external_trigger_enable_q) begin
            start_d = 1'b1;
        end
        // standby stops everything and drops the start bit
        if (standby_req) begin
            start_d = 1'b0;
        end
        // sequencer
        if (run_q && !start_d) begin
            // stopped mid conversion: nothing stored, flag untouched
            run_d   = 1'b0;
            abort_d = 1'b1;
        end else if (!run_q && start_d) begin
            run_d    = 1'b1;
            // single picks the channel, scan begins at channel 0
            chan_d   = scan_d ? 2'h0 : chsel_d[1:0];
            cnt_d    = conv_len(1'b1, speed_d);
            cstart_d = 1'b1;
        end else if (run_q) begin
            if (cnt_q == {{(CW-1){1'b0}}, 1'b1}) begin
                mem_we = 1'b1;
                if (!scan_q) begin
                    flag_d  = 1'b1;
                    start_d = 1'b0;
                    run_d   = 1'b0;
                end else begin
                    cstart_d = 1'b1;
                    cnt_d    = conv_len(1'b0, speed_q);
                    if (chan_q == chsel_q[1:0]) begin
                        flag_d = 1'b1;
                        chan_d = 2'h0;
                    end else begin
                        chan_d = chan_q + 2'h1;
                    end
                end
            end else begin
                cnt_d = cnt_q - {{(CW-1){1'b0}}, 1'b1};
            end
        end
    end

    // register fields, sequencer and core-facing outputs
    always @(posedge aclk) begin
        if (!aresetn) begin
            flag_q       <= 1'b0;
            ie_q         <= 1'b0;
            start_q      <= 1'b0;
            scan_q       <= 1'b0;
            speed_q      <= 1'b0;
            chsel_q      <= 3'h0;
            external_trigger_enable_q       <= 1'b0;
            arm_q        <= 1'b0;
            run_q        <= 1'b0;
            cnt_q        <= {CW{1'b0}};
            chan_q       <= 2'h0;
            conv_start   <= 1'b0;
            conv_abort   <= 1'b0;
            conv_channel <= 2'h0;
            conv_speed   <= 1'b0;
            conversion_end_interrupt <= 1'b0;
        end else begin
            flag_q       <= flag_d;
            ie_q         <= ie_d;
            start_q      <= start_d;
            scan_q       <= scan_d;
            speed_q      <= speed_d;
            chsel_q      <= chsel_d;
            external_trigger_enable_q       <= external_trigger_enable_d;
            arm_q        <= arm_d;
            run_q        <= run_d;
            cnt_q        <= cnt_d;
            chan_q       <= chan_d;
            conv_start   <= cstart_d;
            conv_abort   <= abort_d;
            conv_channel <= chan_d;
            conv_speed   <= speed_d;
            // registered so the request lines up with the flag itself
            conversion_end_interrupt <= flag_d & ie_d;
        end
    end

    // write channels: address and data taken in either order,
    // response one edge after both are held
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q <= 1'b0;
            w_got_q  <= 1'b0;
            waddr_q  <= {AW{1'b0}};
            wbyte_q  <= 8'h00;
            wlane_q  <= 1'b0;
            awready  <= 1'b0;
            wready   <= 1'b0;
            bvalid   <= 1'b0;
            bresp    <= `ACS_RESP_OKAY;
        end else begin
            // ready rises after reset and after each response
            if (!aw_got_q && !bvalid && !(awvalid && awready)) begin
                awready <= 1'b1;
            end
            if (!w_got_q && !bvalid && !(wvalid && wready)) begin
                wready <= 1'b1;
            end
            if (awvalid && awready) begin
                aw_got_q <= 1'b1;
                waddr_q  <= awaddr;
                awready  <= 1'b0;
            end
            if (wvalid && wready) begin
                w_got_q <= 1'b1;
                wbyte_q <= wdata[7:0];
                wlane_q <= wstrb[0];
                wready  <= 1'b0;
            end
            if (wr_fire) begin
                aw_got_q <= 1'b0;
                w_got_q  <= 1'b0;
                bvalid   <= 1'b1;
                // result words are read-only, writes there are dropped
                bresp    <= is_mapped(waddr_q) ? `ACS_RESP_OKAY
                                               : `ACS_RESP_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // read channels: one read at a time, data two edges after address
    // because result words come from the registered memory port
    always @(posedge aclk) begin
        if (!aresetn) begin
            arready   <= 1'b0;
            rd_pend_q <= 1'b0;
            raddr_q   <= {AW{1'b0}};
            rvalid    <= 1'b0;
            rdata     <= 32'h0000_0000;
            rresp     <= `ACS_RESP_OKAY;
        end else begin
            rd_pend_q <= 1'b0;
            if (!rd_pend_q && !rvalid && !(arvalid && arready)) begin
                arready <= 1'b1;
            end
            if (arvalid && arready) begin
                arready   <= 1'b0;
                rd_pend_q <= 1'b1;
                raddr_q   <= araddr;
            end
            if (rd_pend_q) begin
                rvalid <= 1'b1;
                rresp  <= is_mapped(raddr_q) ? `ACS_RESP_OKAY
                                             : `ACS_RESP_SLVERR;
                if (raddr_q == `ACS_OFF_CSR) begin
                    rdata <= {24'h000000, csr_view};
                end else if (raddr_q == `ACS_OFF_TRG) begin
                    // reserved middle bits read as one
                    rdata <= {24'h000000, external_trigger_enable_q, 7'h00} |
                             {24'h000000, `ACS_TRG_RSVD};
                end else if (is_mapped(raddr_q)) begin
                    rdata <= {16'h0000, mem_rdata};
                end else begin
                    rdata <= 32'h0000_0000;
                end
            end
            if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end
endmodule // acs_top

// ===== tb/acs_top_asserts.sv
// port-level assertions for the converter control/status block
`timescale 1ns/100ps
module acs_top_asserts #(
    parameter AW = 8,
    parameter RW = 10,
    parameter CW = 8
) (
    // clock and reset
    input wire       aclk,
    input wire       aresetn,
    // register bus handshakes
    input wire       arvalid,
    input wire       arready,
    input wire       rvalid,
    input wire       bvalid,
    // conversion link and interrupt
    input wire       conv_start,
    input wire       conv_abort,
    input wire [1:0] conv_channel,
    input wire       conv_speed,
    input wire       conversion_end_interrupt
);
    // cycles since the last start; saturates, abort marks the link idle
    reg [7:0] since_q;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // age counter; a restart sooner than the shortest conversion is a fault
    always @(posedge aclk) begin
        if (!aresetn || conv_abort)
            since_q <= 8'hFF;
        else if (conv_start)
            since_q <= 8'h01;
        else if (since_q != 8'hFF)
            since_q <= since_q + 8'h01;
    end

    chk_reset_zero: assert property (
        $rose(aresetn) |-> !conversion_end_interrupt && !conv_start
            && !rvalid && !bvalid)
        else $error("outputs not cleared by reset");
    chk_start_pulse: assert property (
        conv_start |=> !conv_start)
        else $error("start pulse longer than one cycle");
    chk_abort_pulse: assert property (
        conv_abort |-> !conv_start ##1 !conv_abort)
        else $error("abort pulse malformed");
    chk_start_gap: assert property (
        conv_start |-> since_q >= 8'd66)
        else $error("conversion restarted too early");
    chk_irq_fall: assert property (
        $fell(conversion_end_interrupt) |-> $rose(bvalid))
        else $error("interrupt dropped without a register write");
    chk_chan_hold: assert property (
        since_q < 8'd66 && !conv_start && !conv_abort
            |-> $stable(conv_channel))
        else $error("channel moved during a conversion");
    chk_speed_hold: assert property (
        since_q < 8'd66 && !conv_start && !conv_abort
            |-> $stable(conv_speed))
        else $error("speed moved during a conversion");
    chk_read_lat: assert property (
        arvalid && arready |=> !rvalid ##1 rvalid)
        else $error("read data not two cycles after address");
endmodule // acs_top_asserts

bind acs_top acs_top_asserts #(.AW(AW), .RW(RW), .CW(CW)) u_chk (
    .aclk(aclk), .aresetn(aresetn), .arvalid(arvalid),
    .arready(arready), .rvalid(rvalid), .bvalid(bvalid),
    .conv_start(conv_start), .conv_abort(conv_abort),
    .conv_channel(conv_channel), .conv_speed(conv_speed),
    .conversion_end_interrupt(conversion_end_interrupt)
);

// ===== tb/acs_top_tb.sv
// self-checking bench for the converter control/status block
`timescale 1ns/100ps
`include "acs_consts.vh"
module acs_top_tb;
    // drives toward the design
    reg         aclk = 1'b0;
    reg         aresetn = 1'b0;
    reg  [7:0]  awaddr = 8'h00;
    reg  [7:0]  araddr = 8'h00;
    reg  [31:0] wdata = 32'h0;
    reg  [3:0]  wstrb = 4'hF;
    reg         awvalid = 1'b0;
    reg         wvalid = 1'b0;
    reg         bready = 1'b0;
    reg         arvalid = 1'b0;
    reg         rready = 1'b0;
    reg  [9:0]  conv_result = 10'h000;
    reg         standby_req = 1'b0;
    reg         external_trigger_input = 1'b1;
    // design outputs
    wire        awready, wready, bvalid, arready, rvalid;
    wire [1:0]  bresp, rresp, conv_channel;
    wire [31:0] rdata;
    wire        conv_start, conv_abort, conv_speed;
    wire        conversion_end_interrupt;
    // counters and event log
    int         n_mismatch = 0;
    int         cmp_count = 0;
    int         cyc = 0;
    int         irq_cyc = 0;
    int         n_abort = 0;
    int         sq[$];
    logic [1:0] cq[$];
    bit         irq_d = 1'b0;
    int         i, n0, a0;
    reg  [31:0] rv;
    reg  [1:0]  rr;
    reg  [7:0]  m;
    reg  [27:0] row;
    // rows: control value, core result, channel, cycles to end
    reg  [27:0] rows [0:3] = '{{8'h6C, 10'h3FF, 2'd0, 8'd70},
                               {8'h69, 10'h155, 2'd1, 8'd70},
                               {8'h62, 10'h2AA, 2'd2, 8'd134},
                               {8'h6F, 10'h001, 2'd3, 8'd70}};

    acs_top dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .conv_start(conv_start),
        .conv_abort(conv_abort), .conv_channel(conv_channel),
        .conv_speed(conv_speed), .conv_result(conv_result),
        .standby_req(standby_req),
        .external_trigger_input(external_trigger_input),
        .conversion_end_interrupt(conversion_end_interrupt)
    );

    // 25 MHz clock
    always #20 aclk = ~aclk;

    // log each start with its channel, each abort, each interrupt rise
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (conv_start === 1'b1) begin
            sq.push_back(cyc);
            cq.push_back(conv_channel);
        end
        if (conv_abort === 1'b1)
            n_abort <= n_abort + 1;
        if (conversion_end_interrupt === 1'b1 && !irq_d)
            irq_cyc <= cyc;
        irq_d <= (conversion_end_interrupt === 1'b1);
    end

    // compare and count; four-state so an unknown never matches
    task automatic check(input [31:0] got, input [31:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("BAD t=%0t got %h want %h", $time, got, exp);
        end
    endtask

    // write: address and data offered together, each dropped when taken
    task automatic wr(input [7:0] a, input [31:0] d, output [1:0] r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
        // one idle edge so the next call never reassigns in this step
        @(posedge aclk);
    endtask

    // read: address held until taken, rready held until data comes
    task automatic rd(input [7:0] a, output [31:0] d, output [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic wok(input [7:0] a, input [31:0] d);
        wr(a, d, rr);
        check(rr, `ACS_RESP_OKAY);
    endtask

    task automatic rchk(input [7:0] a, input [31:0] e);
        rd(a, rv, rr);
        check(rv, e);
        check(rr, `ACS_RESP_OKAY);
    endtask

    // bounded wait for the end-of-conversion interrupt
    task automatic wait_irq;
        int n;
        n = 0;
        while (conversion_end_interrupt !== 1'b1 && n < 400) begin
            @(posedge aclk);
            n = n + 1;
        end
        check(n < 400, 1);
    endtask

    // reset for three edges, then look at the cleared state
    task automatic rst_chk;
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check(conversion_end_interrupt, 1'b0);
        rchk(8'h00, 32'h00);
        rchk(8'h04, 32'h7E);
        rchk(8'h14, 32'h00);
    endtask

    task conclude;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // hang guard: the whole run needs under two thousand cycles
    initial begin
        repeat (20000) @(posedge aclk);
        n_mismatch = n_mismatch + 1;
        conclude();
    end

    initial begin
        rst_chk();
        // single conversions: every channel, both speeds, top bit ignored
        for (i = 0; i < 4; i = i + 1) begin
            row = rows[i];
            m = row[27:20] & 8'h5F;
            conv_result <= row[19:10];
            n0 = sq.size();
            wok(8'h00, {24'h0, row[27:20]});
            wait_irq();
            check(conv_speed, row[23]);
            wok(8'h00, {24'h0, m});
            check(conversion_end_interrupt, 1'b1);
            check(cq[n0], row[9:8]);
            check(irq_cyc - sq[n0], row[7:0]);
            rchk(8'h08 + {4'h0, row[9:8], 2'b00},
                 {16'h0, row[19:10], 6'h00});
            rchk(8'h00, {24'h0, m | 8'h80});
            wok(8'h00, {24'h0, m});
            rchk(8'h00, {24'h0, m});
            check(conversion_end_interrupt, 1'b0);
        end
        // flag set with interrupt disabled, then enabled without a clear
        wok(8'h00, 32'h29);
        repeat (80) @(posedge aclk);
        check(conversion_end_interrupt, 1'b0);
        wok(8'h00, 32'h49);
        check(conversion_end_interrupt, 1'b1);
        rchk(8'h00, 32'hC9);
        wok(8'h00, 32'h00);
        // scan over channels 0..2, then stop in mid conversion
        n0 = sq.size();
        a0 = n_abort;
        conv_result <= 10'h2C3;
        wok(8'h00, 32'h7E);
        wait_irq();
        conv_result <= 10'h0F0;
        rchk(8'h00, 32'hFE);
        wok(8'h00, 32'h5E);
        for (i = 0; i < 4; i = i + 1)
            check(cq[n0 + i], i % 3);
        check(sq[n0 + 1] - sq[n0], 70);
        check(sq[n0 + 2] - sq[n0 + 1], 66);
        check(irq_cyc - sq[n0 + 2], 66);
        check(n_abort, a0 + 1);
        rchk(8'h00, 32'h5E);
        rchk(8'h10, {16'h0, 10'h2C3, 6'h00});
        // result words ignore writes; aborted pass left word 0 alone
        wok(8'h08, 32'hFFFF);
        rchk(8'h08, {16'h0, 10'h2C3, 6'h00});
        // standby stops a scan and drops the start bit
        wok(8'h00, 32'h30);
        repeat (20) @(posedge aclk);
        standby_req <= 1'b1;
        repeat (3) @(posedge aclk);
        standby_req <= 1'b0;
        check(n_abort, a0 + 2);
        rchk(8'h00, 32'h10);
        // falling trigger edge starts a single conversion when enabled
        wok(8'h04, 32'h80);
        rchk(8'h04, 32'hFE);
        wok(8'h00, 32'h41);
        n0 = sq.size();
        external_trigger_input <= 1'b0;
        wait_irq();
        external_trigger_input <= 1'b1;
        check(cq[n0], 1);
        rchk(8'h00, 32'hC1);
        wok(8'h00, 32'h00);
        wok(8'h04, 32'h00);
        n0 = sq.size();
        external_trigger_input <= 1'b0;
        repeat (20) @(posedge aclk);
        check(sq.size(), n0);
        external_trigger_input <= 1'b1;
        // unmapped places answer with an error
        wr(8'h18, 32'h1, rr);
        check(rr, `ACS_RESP_SLVERR);
        rd(8'h40, rv, rr);
        check(rr, `ACS_RESP_SLVERR);
        check(rv, 32'h0);
        // reset in the middle of a scan
        wok(8'h00, 32'h7B);
        repeat (5) @(posedge aclk);
        rst_chk();
        conclude();
    end
endmodule // acs_top_tb
